// file: rtl/cbadj_pkg.sv
package cbadj_pkg;

  // ------------------------------------------------------------
  // Operation codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CBADJ_OP_NONE     = 2'h0,
    CBADJ_OP_INV_MEM  = 2'h1,
    CBADJ_OP_INV_WORK = 2'h3,
    CBADJ_OP_BCD_ADJ  = 2'h2
  } cbadj_op_t;

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  localparam int unsigned DATA_W        = 8;
  localparam logic [3:0]  NIBBLE_MAX    = 4'h9;
  localparam logic [7:0]  ADJ_LOW       = 8'h06;
  localparam logic [7:0]  ADJ_HIGH      = 8'h60;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic        RST_BIT       = 1'b0;

endpackage

// file: rtl/cbadj_bcd_corr.sv
module cbadj_bcd_corr (
  // Operand and flags
  input  wire logic [7:0] work_val,
  input  wire logic       nibble_carry_flag,
  input  wire logic       carry_in,
  // Result
  output logic      [7:0] adj_val,
  output logic            carry_out
);

  logic       low_fix;
  logic       high_fix;
  logic [8:0] low_sum;
  logic [8:0] sum;

  always_comb begin
    low_fix   = (work_val[3:0] > cbadj_pkg::NIBBLE_MAX) ||
                nibble_carry_flag;
    low_sum   = {1'b0, work_val}
              + {1'b0, (low_fix ? cbadj_pkg::ADJ_LOW : 8'h00)};
    // High nibble judged after the low fix, else a sum of 100 seen
    // as 9a would end as a0 with no carry
    high_fix  = (low_sum[7:4] > cbadj_pkg::NIBBLE_MAX) || low_sum[8] ||
                carry_in;
    sum       = low_sum
              + {1'b0, (high_fix ? cbadj_pkg::ADJ_HIGH : 8'h00)};
    // Only low byte stored; overflow goes to carry
    adj_val   = sum[7:0];
    carry_out = carry_in | sum[8] | high_fix;
  end

endmodule

// file: rtl/cbadj_top.sv
// Operation
// - Invert-in-place writes the bitwise inverse back to the same byte.
// - Invert-to-working loads the inverse into working reg, memory kept.
// - Both inversions set the zero flag from the result, nothing else.
// - BCD adjust adds 6 to low nibble if above 9 or nibble carry set.
// - BCD adjust adds 6 to high nibble if above 9 or carry set.
// - BCD adjust writes its result to memory, not the working reg.
// - BCD adjust changes only carry, showing a decimal sum of 100 up.
module cbadj_top (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Instruction from decoder
  input  wire logic                op_valid,
  input  wire cbadj_pkg::cbadj_op_t op_code,
  input  wire logic [7:0]          mem_addr,
  input  wire logic [7:0]          mem_rdata,
  // Current core state
  input  wire logic [7:0]          work_in,
  input  wire logic                zero_in,
  input  wire logic                carry_in,
  input  wire logic                nibble_carry_flag,
  // Memory write
  output logic                     mem_we_ff,
  output logic [7:0]               mem_waddr_ff,
  output logic [7:0]               mem_wdata_ff,
  // Working register write
  output logic                     work_we_ff,
  output logic [7:0]               work_wdata_ff,
  // Flag updates
  output logic                     zero_we_ff,
  output logic                     zero_ff,
  output logic                     carry_we_ff,
  output logic                     carry_ff
);

  // ------------------------------------------------------------
  // Correction datapath
  // ------------------------------------------------------------
  logic [7:0] adj_val;
  logic       adj_carry;
  logic [7:0] inv_val;

  cbadj_bcd_corr u_corr (
    .work_val          (work_in),
    .nibble_carry_flag (nibble_carry_flag),
    .carry_in          (carry_in),
    .adj_val           (adj_val),
    .carry_out         (adj_carry)
  );

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  logic       nxt_mem_we;
  logic [7:0] nxt_mem_waddr;
  logic [7:0] nxt_mem_wdata;
  logic       nxt_work_we;
  logic [7:0] nxt_work_wdata;
  logic       nxt_zero_we;
  logic       nxt_zero;
  logic       nxt_carry_we;
  logic       nxt_carry;

  always_comb begin
    inv_val        = ~mem_rdata;
    nxt_mem_we     = 1'b0;
    nxt_mem_waddr  = mem_addr;
    nxt_mem_wdata  = cbadj_pkg::RST_BYTE;
    nxt_work_we    = 1'b0;
    nxt_work_wdata = cbadj_pkg::RST_BYTE;
    nxt_zero_we    = 1'b0;
    nxt_zero       = zero_in;
    nxt_carry_we   = 1'b0;
    nxt_carry      = carry_in;
    if (op_valid) begin
      unique case (op_code)
        cbadj_pkg::CBADJ_OP_INV_MEM: begin
          nxt_mem_we    = 1'b1;
          nxt_mem_wdata = inv_val;
          nxt_zero_we   = 1'b1;
          nxt_zero      = (inv_val == 8'h00);
        end
        cbadj_pkg::CBADJ_OP_INV_WORK: begin
          // Memory untouched: write enable stays low
          nxt_work_we    = 1'b1;
          nxt_work_wdata = inv_val;
          nxt_zero_we    = 1'b1;
          nxt_zero       = (inv_val == 8'h00);
        end
        cbadj_pkg::CBADJ_OP_BCD_ADJ: begin
          nxt_mem_we    = 1'b1;
          nxt_mem_wdata = adj_val;
          nxt_carry_we  = 1'b1;
          nxt_carry     = adj_carry;
        end
        cbadj_pkg::CBADJ_OP_NONE: begin
          nxt_mem_we = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_we_ff     <= cbadj_pkg::RST_BIT;
      mem_waddr_ff  <= cbadj_pkg::RST_BYTE;
      mem_wdata_ff  <= cbadj_pkg::RST_BYTE;
      work_we_ff    <= cbadj_pkg::RST_BIT;
      work_wdata_ff <= cbadj_pkg::RST_BYTE;
      zero_we_ff    <= cbadj_pkg::RST_BIT;
      zero_ff       <= cbadj_pkg::RST_BIT;
      carry_we_ff   <= cbadj_pkg::RST_BIT;
      carry_ff      <= cbadj_pkg::RST_BIT;
    end else begin
      mem_we_ff     <= nxt_mem_we;
      mem_waddr_ff  <= nxt_mem_waddr;
      mem_wdata_ff  <= nxt_mem_wdata;
      work_we_ff    <= nxt_work_we;
      work_wdata_ff <= nxt_work_wdata;
      zero_we_ff    <= nxt_zero_we;
      zero_ff       <= nxt_zero;
      carry_we_ff   <= nxt_carry_we;
      carry_ff      <= nxt_carry;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_inv_mem_data: assert property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_INV_MEM |=>
      mem_we_ff && mem_wdata_ff == ~$past(mem_rdata)
      && mem_waddr_ff == $past(mem_addr))
    else $error("invert in place wrong data");

  a_inv_work_data: assert property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_INV_WORK |=>
      work_we_ff && !mem_we_ff && work_wdata_ff == ~$past(mem_rdata))
    else $error("invert to working wrong");

  a_inv_flags: assert property (
    op_valid && (op_code == cbadj_pkg::CBADJ_OP_INV_MEM ||
                 op_code == cbadj_pkg::CBADJ_OP_INV_WORK) |=>
      zero_we_ff && !carry_we_ff
      && zero_ff == ($past(mem_rdata) == 8'hff))
    else $error("inversion flag update wrong");

  a_bcd_low: assert property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_BCD_ADJ
    && work_in[3:0] <= 4'h9 && !nibble_carry_flag
    && work_in[7:4] <= 4'h9 && !carry_in |=>
      mem_wdata_ff == $past(work_in))
    else $error("bcd adjust changed clean value");

  a_bcd_high: assert property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_BCD_ADJ
    && work_in[7:4] > 4'h9 && work_in[3:0] <= 4'h9
    && !nibble_carry_flag |=>
      mem_wdata_ff == 8'($past(work_in) + 8'h60) && carry_ff)
    else $error("bcd high correction wrong");

  a_bcd_target: assert property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_BCD_ADJ |=>
      mem_we_ff && !work_we_ff && !zero_we_ff)
    else $error("bcd adjust wrong target");

  a_bcd_carry: assert property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_BCD_ADJ && carry_in |=>
      carry_we_ff && carry_ff)
    else $error("bcd adjust lost carry");

  a_bcd_wrap: assert property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_BCD_ADJ
    && work_in == 8'h9a && !nibble_carry_flag && !carry_in |=>
      mem_wdata_ff == 8'h00 && carry_ff)
    else $error("bcd wrap wrong");

  a_bcd_low_fix: assert property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_BCD_ADJ
    && work_in[3:0] > 4'h9 && work_in[7:4] <= 4'h8
    && !carry_in |=>
      mem_wdata_ff == 8'($past(work_in) + 8'h06) && !carry_ff)
    else $error("bcd low correction wrong");

  a_bcd_both_fix: assert property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_BCD_ADJ
    && nibble_carry_flag && carry_in |=>
      mem_wdata_ff == 8'($past(work_in) + 8'h66) && carry_ff)
    else $error("bcd full correction wrong");

  // A sum of 100 that shows as 9a must still end as 00 with carry,
  // since the low fix pushes the high nibble past nine
  a_bcd_post_low: assert property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_BCD_ADJ
    && work_in[7:4] == 4'h9 && work_in[3:0] > 4'h9
    && !carry_in |=>
      mem_wdata_ff == 8'($past(work_in) + 8'h66) && carry_ff)
    else $error("bcd hundred carry wrong");

  c_inv_mem: cover property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_INV_MEM);
  c_inv_work: cover property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_INV_WORK);
  c_bcd_both: cover property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_BCD_ADJ
    && nibble_carry_flag && carry_in);
  c_bcd_wrap: cover property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_BCD_ADJ
    && work_in[7:4] == 4'h9 && work_in[3:0] > 4'h9);
  c_bcd_plain: cover property (
    op_valid && op_code == cbadj_pkg::CBADJ_OP_BCD_ADJ
    && work_in[3:0] <= 4'h9 && !nibble_carry_flag);

endmodule

// file: dv/cbadj_core_model.sv
module cbadj_core_model (
  // Clock and lookup
  input  wire logic       clk,
  input  wire logic [7:0] mem_addr,
  output logic      [7:0] mem_rdata,
  // Writes from block
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_waddr,
  input  wire logic [7:0] mem_wdata,
  input  wire logic       work_we,
  input  wire logic [7:0] work_wdata,
  input  wire logic       zero_we,
  input  wire logic       zero_nxt,
  input  wire logic       carry_we,
  input  wire logic       carry_nxt,
  // Core state
  output logic      [7:0] work_ff,
  output logic            zero_ff,
  output logic            carry_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_ff [256];
  // Read is combinational: the block samples it in the cycle of the op
  assign mem_rdata = mem_ff[mem_addr];
  // Plain always, so the bench may preload state between ops
  always @(posedge clk) begin
    if (mem_we) mem_ff[mem_waddr] <= mem_wdata;
    if (work_we) work_ff <= work_wdata;
    if (zero_we) zero_ff <= zero_nxt;
    if (carry_we) carry_ff <= carry_nxt;
  end
endmodule

// file: dv/tb_cbadj_top.sv
module tb_cbadj_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk, sys_rst, op_valid, nib_c;
  cbadj_pkg::cbadj_op_t op_code;
  logic [7:0]           addr, rdata, work, m_wa, m_wd, w_wd;
  logic                 m_we, w_we, z_we, z_nx, c_we, c_nx, zero, carry;
  int                   num_errors = 0;
  int                   tests_run = 0;
  logic [18:0]          tab [9] = '{{8'h15, 2'b00, 8'h15, 1'b0},
    {8'h1b, 2'b00, 8'h21, 1'b0}, {8'h12, 2'b10, 8'h18, 1'b0},
    {8'ha2, 2'b00, 8'h02, 1'b1}, {8'h31, 2'b01, 8'h91, 1'b1},
    {8'h9a, 2'b00, 8'h00, 1'b1}, {8'h99, 2'b11, 8'hff, 1'b1},
    {8'h09, 2'b10, 8'h0f, 1'b0}, {8'h0a, 2'b00, 8'h10, 1'b0}};

  cbadj_top cbadj_top_inst (.clk(clk), .sys_rst(sys_rst),
    .op_valid(op_valid), .op_code(op_code), .mem_addr(addr),
    .mem_rdata(rdata), .work_in(work), .zero_in(zero), .carry_in(carry),
    .nibble_carry_flag(nib_c), .mem_we_ff(m_we), .mem_waddr_ff(m_wa),
    .mem_wdata_ff(m_wd), .work_we_ff(w_we), .work_wdata_ff(w_wd),
    .zero_we_ff(z_we), .zero_ff(z_nx), .carry_we_ff(c_we),
    .carry_ff(c_nx));
  cbadj_core_model cbadj_core_model_inst (.clk(clk), .mem_addr(addr),
    .mem_rdata(rdata), .mem_we(m_we), .mem_waddr(m_wa), .mem_wdata(m_wd),
    .work_we(w_we), .work_wdata(w_wd), .zero_we(z_we), .zero_nxt(z_nx),
    .carry_we(c_we), .carry_nxt(c_nx), .work_ff(work), .zero_ff(zero),
    .carry_ff(carry));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic preset(logic [7:0] m, logic [7:0] w, logic z, logic c);
    cbadj_core_model_inst.mem_ff[8'h80] = m;
    cbadj_core_model_inst.work_ff = w;
    cbadj_core_model_inst.zero_ff = z;
    cbadj_core_model_inst.carry_ff = c;
  endtask
  // Ends on the falling edge after the model has taken the writes
  task automatic run_op(cbadj_pkg::cbadj_op_t code);
    @(negedge clk);
    op_valid = 1'b1;
    op_code = code;
    addr = 8'h80;
    @(negedge clk);
    op_valid = 1'b0;
    @(negedge clk);
  endtask
  task automatic expect_state(logic [7:0] m, logic [7:0] w, logic z,
                              logic c);
    check("mem", m, cbadj_core_model_inst.mem_ff[8'h80]);
    check("work", w, work);
    check("zero", {7'h00, z}, {7'h00, zero});
    check("carry", {7'h00, c}, {7'h00, carry});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_inv_mem;
    preset(8'ha5, 8'h33, 1'b1, 1'b1);
    run_op(cbadj_pkg::CBADJ_OP_INV_MEM);
    expect_state(8'h5a, 8'h33, 1'b0, 1'b1);
    preset(8'hff, 8'h33, 1'b0, 1'b0);
    run_op(cbadj_pkg::CBADJ_OP_INV_MEM);
    expect_state(8'h00, 8'h33, 1'b1, 1'b0);
  endtask
  task automatic test_inv_work;
    preset(8'h0f, 8'h00, 1'b1, 1'b1);
    run_op(cbadj_pkg::CBADJ_OP_INV_WORK);
    expect_state(8'h0f, 8'hf0, 1'b0, 1'b1);
    preset(8'hff, 8'h5a, 1'b0, 1'b0);
    run_op(cbadj_pkg::CBADJ_OP_INV_WORK);
    expect_state(8'hff, 8'h00, 1'b1, 1'b0);
  endtask
  task automatic test_bcd;
    for (int i = 0; i < 9; i++) begin
      logic [18:0] t;
      t = tab[i];
      // Zero flag preset alternates so a stray zero write shows up
      preset(8'h55, t[18:11], i[0], t[9]);
      nib_c = t[10];
      run_op(cbadj_pkg::CBADJ_OP_BCD_ADJ);
      expect_state(t[8:1], t[18:11], i[0], t[0]);
      check("bcd carry", {7'h00, t[0]}, {7'h00, carry});
    end
    // No operation must leave all core state alone
    preset(8'h55, 8'h9a, 1'b0, 1'b0);
    run_op(cbadj_pkg::CBADJ_OP_NONE);
    expect_state(8'h55, 8'h9a, 1'b0, 1'b0);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #50us;
    num_errors++;
    print_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    op_valid = 1'b0;
    op_code = cbadj_pkg::CBADJ_OP_NONE;
    addr = 8'h00;
    nib_c = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    test_inv_mem();
    test_inv_work();
    test_bcd();
    print_verdict();
  end
endmodule
